// File: shared/cisd_pkg.sv
package cisd_pkg;

  // ----------------------------------------------------------------------
  // Channel function codes
  // ----------------------------------------------------------------------
  localparam int           CISD_CHANNELS = 2;
  localparam logic [7:0]   FN_OFF        = 8'hFF;
  localparam logic [7:0]   FN_4M_27648   = 8'h30;
  localparam logic [7:0]   FN_0M_27648   = 8'h31;
  localparam logic [7:0]   FN_4M_16384   = 8'h40;
  localparam logic [7:0]   FN_0M_16384   = 8'h41;
  localparam logic [7:0]   FN_DEFAULT    = 8'h30;

  // ----------------------------------------------------------------------
  // Scaling: current in microamps, value = (I - offset) * full / span
  // ----------------------------------------------------------------------
  localparam logic signed [15:0] CEIL_27648  = 16'sh7EFF;
  localparam logic signed [15:0] FLOOR_27648 = 16'shED00;
  localparam logic signed [15:0] CEIL_16384  = 16'sh5000;
  localparam logic signed [15:0] FLOOR_16384 = 16'shF333;
  localparam longint             FULL_27648  = 27648;
  localparam longint             FULL_16384  = 16384;
  localparam longint             SPAN_0M_UA  = 20000;
  localparam longint             SPAN_4M_UA  = 16000;
  localparam logic signed [16:0] OFFS_4M_UA  = 17'sh00FA0;
  localparam int                 SCALE_FRAC  = 24;
  localparam longint             ONE_FIX     = longint'(1) << SCALE_FRAC;
  localparam logic signed [31:0] MUL_0M_27648 = 32'((FULL_27648 * ONE_FIX + SPAN_0M_UA / 2) / SPAN_0M_UA);
  localparam logic signed [31:0] MUL_0M_16384 = 32'((FULL_16384 * ONE_FIX + SPAN_0M_UA / 2) / SPAN_0M_UA);
  localparam logic signed [31:0] MUL_4M_27648 = 32'((FULL_27648 * ONE_FIX + SPAN_4M_UA / 2) / SPAN_4M_UA);
  localparam logic signed [31:0] MUL_4M_16384 = 32'((FULL_16384 * ONE_FIX + SPAN_4M_UA / 2) / SPAN_4M_UA);

  // ----------------------------------------------------------------------
  // Diagnostic record access and layout
  // ----------------------------------------------------------------------
  localparam logic [7:0]  REC_HEAD  = 8'h00;
  localparam logic [7:0]  REC_FULL  = 8'h01;
  localparam logic [7:0]  REC_FN0   = 8'h80;
  localparam logic [7:0]  REC_FN1   = 8'h81;
  localparam logic [15:0] IDX_HEAD  = 16'h2F00;
  localparam logic [15:0] IDX_FULL  = 16'h2F01;
  localparam logic [4:0]  LEN_HEAD  = 5'h04;
  localparam logic [4:0]  LEN_FULL  = 5'h14;
  localparam int          B_SUMMARY = 0;
  localparam int          B_MODINFO = 1;
  localparam int          B_SECOND  = 3;
  localparam int          B_CHKIND  = 4;
  localparam int          B_DIAG_BITS_PER_CHANNEL  = 5;
  localparam int          B_CHANNEL_COUNT   = 6;
  localparam int          B_CHANNEL_ERROR_SUMMARY   = 7;
  localparam int          B_CH0     = 8;
  localparam int          B_STAMP   = 16;
  localparam logic [7:0]  VAL_MODINFO = 8'h15;
  localparam logic [7:0]  VAL_CHKIND  = 8'h71;
  localparam logic [7:0]  VAL_DIAG_BITS_PER_CHANNEL  = 8'h08;
  localparam logic [7:0]  VAL_CHANNEL_COUNT   = 8'h02;

  // Bit positions
  localparam int SUM_MODFAIL  = 0;
  localparam int SUM_INTERNAL = 1;
  localparam int SUM_EXTERNAL = 2;
  localparam int SUM_CHANNEL  = 3;
  localparam int SUM_AUX      = 4;
  localparam int SUM_PARAM    = 7;
  localparam int CH_PARAM     = 0;
  localparam int CH_UNDER     = 6;
  localparam int CH_OVER      = 7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          US_TICK_NS    = 1000;
  localparam logic [6:0]  US_TICK_CYC   = 7'(US_TICK_NS / CLK_PERIOD_NS);

endpackage : cisd_pkg

// File: rtl/cisd_scaler.sv
`timescale 1ns/1ps
module cisd_scaler
  import cisd_pkg::*;
(
  input  wire logic        [7:0]  code_in,
  input  wire logic signed [15:0] current_in,
  output logic signed      [15:0] value_out,
  output logic                    over_out,
  output logic                    under_out
);

  logic signed [16:0] offs;
  logic signed [31:0] mul;
  logic signed [15:0] ceil_v;
  logic signed [15:0] floor_v;
  logic signed [16:0] diff;
  logic signed [48:0] prod;
  logic signed [48:0] rnd;
  logic signed [24:0] raw;

  // ----------------------------------------------------------------------
  // Range selection
  // ----------------------------------------------------------------------
  // Pick offset, fixed-point gain and limits for the active code
  always_comb begin
    offs    = '0;
    mul     = MUL_0M_27648;
    ceil_v  = CEIL_27648;
    floor_v = FLOOR_27648;
    case (code_in)
      FN_0M_27648: mul = MUL_0M_27648;
      FN_0M_16384: begin
        mul     = MUL_0M_16384;
        ceil_v  = CEIL_16384;
        floor_v = FLOOR_16384;
      end
      FN_4M_27648: begin
        offs = OFFS_4M_UA;
        mul  = MUL_4M_27648;
      end
      FN_4M_16384: begin
        offs    = OFFS_4M_UA;
        mul     = MUL_4M_16384;
        ceil_v  = CEIL_16384;
        floor_v = FLOOR_16384;
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------------
  // Arithmetic and limits
  // ----------------------------------------------------------------------
  // Rounded product keeps full scale exact despite the reciprocal gain
  assign diff = 17'(current_in) - offs;
  assign prod = 49'(diff) * 49'(mul);
  assign rnd  = prod + (49'sd1 <<< (SCALE_FRAC - 1));
  assign raw  = rnd[48:SCALE_FRAC];

  // Values past the limits stick at the limit code and raise the flag
  always_comb begin
    over_out  = raw >= 25'(ceil_v);
    under_out = raw <= 25'(floor_v);
    if (over_out) begin
      value_out = ceil_v;
    end else if (under_out) begin
      value_out = floor_v;
    end else begin
      value_out = raw[15:0];
    end
  end

endmodule : cisd_scaler

// File: rtl/cisd_top.sv
`timescale 1ns/1ps
// Behaviour
// - Code FFh disables channel, no scaling
// - Code 31h: 0..20 mA to 0..27648
// - 31h overrange ceiling 32511 at 23.52 mA
// - 31h underrange floor -4864 at -3.52 mA
// - Code 41h: 0..20 mA to 0..16384
// - 41h overrange ceiling 20480 at 25 mA
// - 41h underrange floor -3277 at -4 mA
// - Code 30h: 4..20 mA to 0..27648
// - 30h overrange 32511 at 22.81 mA
// - 30h underrange -4864 at 1.19 mA
// - Code 40h: 4..20 mA to 0..16384
// - 40h overrange 20480 at 24 mA
// - 40h underrange -3277 at 0.8 mA
// - No interrupt; error lights channel indicator, recorded
// - Record parameter, overflow and underflow errors
// - Record 01h full, 00h first 4 bytes
// - Index 2F01h full, 2F00h first 4
// - Fixed byte order of diagnostic record
// - Descriptive bytes fixed; error bytes reset zero
// - Summary bits 0..2: failure, internal, external
// - Summary bits 3,4,7; bits 6..5 zero
// - Channel byte bits 0, 6, 7
// - Microsecond timer wraps, stamped on events
module cisd_top
  import cisd_pkg::*;
#(
  parameter int VAL_W = 16
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    meas_valid_in,
  input  wire logic                    meas_chan_in,
  input  wire logic signed [VAL_W-1:0] meas_current_in,
  output logic                         meas_ready_out,
  output logic                         out_valid_out,
  input  wire logic                    out_ready_in,
  output logic                         out_chan_out,
  output logic signed      [VAL_W-1:0] out_value_out,
  input  wire logic                    rd_en_in,
  input  wire logic                    rd_by_index_in,
  input  wire logic        [7:0]       rd_record_in,
  input  wire logic        [15:0]      rd_index_in,
  input  wire logic        [4:0]       rd_byte_in,
  output logic                         rd_valid_out,
  output logic             [7:0]       rd_data_out,
  output logic                         rd_err_out,
  input  wire logic                    wr_en_in,
  input  wire logic        [7:0]       wr_record_in,
  input  wire logic        [7:0]       wr_data_in,
  input  wire logic                    fault_module_in,
  input  wire logic                    fault_internal_in,
  input  wire logic                    aux_missing_in,
  output logic             [1:0]       chan_led_out,
  output logic                         module_led_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // A code is usable when it names one of the four scalings
  function automatic logic cisd_fn_known(input logic [7:0] code);
    cisd_fn_known = (code == FN_0M_27648) || (code == FN_0M_16384) ||
                    (code == FN_4M_27648) || (code == FN_4M_16384);
  endfunction : cisd_fn_known

  logic [7:0]              fn_q [CISD_CHANNELS];
  logic [7:0]              sel_fn;
  logic signed [VAL_W-1:0] sc_value;
  logic                    sc_over;
  logic                    sc_under;
  logic                    acc;
  logic                    push;
  logic                    head_v_q;
  logic                    head_c_q;
  logic signed [VAL_W-1:0] head_d_q;
  logic                    skid_v_q;
  logic                    skid_c_q;
  logic signed [VAL_W-1:0] skid_d_q;
  logic                    ready_q;
  logic [7:0]              channel_error_summary_q [CISD_CHANNELS];
  logic [7:0]              channel_error_summary_d [CISD_CHANNELS];
  logic [7:0]              summary_q;
  logic [7:0]              summary_d;
  logic [7:0]              chsum_d;
  logic [6:0]              div_q;
  logic                    us_tick;
  logic [31:0]             us_q;
  logic [31:0]             stamp_q;
  logic                    diag_event;
  logic [7:0]              rec_b [LEN_FULL];
  logic                    rd_full;
  logic                    rd_head;
  logic [1:0]              led_q;
  logic                    mled_q;
  logic                    rd_v_q;
  logic [7:0]              rd_d_q;
  logic                    rd_e_q;

  // ----------------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------------
  // Parameter records 80h/81h set the codes; any byte is stored, odd
  // values are flagged as parameter errors rather than refused
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fn_q[0] <= FN_DEFAULT;
      fn_q[1] <= FN_DEFAULT;
    end else if (wr_en_in && wr_record_in == REC_FN0) begin
      fn_q[0] <= wr_data_in;
    end else if (wr_en_in && wr_record_in == REC_FN1) begin
      fn_q[1] <= wr_data_in;
    end
  end

  // ----------------------------------------------------------------------
  // Scaling
  // ----------------------------------------------------------------------
  assign sel_fn = fn_q[meas_chan_in];

  cisd_scaler u_scaler (
    .code_in    (sel_fn),
    .current_in (meas_current_in),
    .value_out  (sc_value),
    .over_out   (sc_over),
    .under_out  (sc_under)
  );

  // Samples of disabled or misconfigured channels are swallowed
  assign acc  = meas_valid_in && ready_q;
  assign push = acc && cisd_fn_known(sel_fn);

  // ----------------------------------------------------------------------
  // Two-entry output buffer
  // ----------------------------------------------------------------------
  // Head drives the ports; skid catches the word taken while the
  // receiver stalls, so ready can stay a plain flop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      head_v_q <= 1'b0;
      head_c_q <= 1'b0;
      head_d_q <= '0;
      skid_v_q <= 1'b0;
      skid_c_q <= 1'b0;
      skid_d_q <= '0;
    end else if (!head_v_q || out_ready_in) begin
      if (skid_v_q) begin
        head_v_q <= 1'b1;
        head_c_q <= skid_c_q;
        head_d_q <= skid_d_q;
        skid_v_q <= 1'b0;
      end else begin
        head_v_q <= push;
        head_c_q <= meas_chan_in;
        head_d_q <= sc_value;
      end
    end else if (push) begin
      skid_v_q <= 1'b1;
      skid_c_q <= meas_chan_in;
      skid_d_q <= sc_value;
    end
  end

  // Ready drops once the skid entry will be occupied
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ready_q <= 1'b1;
    end else if (!head_v_q || out_ready_in) begin
      ready_q <= 1'b1;
    end else if (push || skid_v_q) begin
      ready_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Channel error bytes
  // ----------------------------------------------------------------------
  // Range bits follow the latest sample, so they clear on a good one
  always_comb begin
    for (int c = 0; c < CISD_CHANNELS; c++) begin
      channel_error_summary_d[c] = channel_error_summary_q[c];
      channel_error_summary_d[c][CH_PARAM] = !cisd_fn_known(fn_q[c]) && fn_q[c] != FN_OFF;
      if (!cisd_fn_known(fn_q[c])) begin
        channel_error_summary_d[c][CH_OVER]  = 1'b0;
        channel_error_summary_d[c][CH_UNDER] = 1'b0;
      end else if (push && meas_chan_in == c[0]) begin
        channel_error_summary_d[c][CH_OVER]  = sc_over;
        channel_error_summary_d[c][CH_UNDER] = sc_under;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      channel_error_summary_q[0] <= '0;
      channel_error_summary_q[1] <= '0;
    end else begin
      channel_error_summary_q[0] <= channel_error_summary_d[0];
      channel_error_summary_q[1] <= channel_error_summary_d[1];
    end
  end

  // ----------------------------------------------------------------------
  // Summary byte
  // ----------------------------------------------------------------------
  // Range problems count as external errors; bits 6..5 stay zero
  always_comb begin
    summary_d = '0;
    for (int c = 0; c < CISD_CHANNELS; c++) begin
      chsum_d[c] = |channel_error_summary_d[c];
      summary_d[SUM_EXTERNAL] = summary_d[SUM_EXTERNAL] |
                                channel_error_summary_d[c][CH_OVER] | channel_error_summary_d[c][CH_UNDER];
      summary_d[SUM_PARAM] = summary_d[SUM_PARAM] | channel_error_summary_d[c][CH_PARAM];
    end
    chsum_d[7:CISD_CHANNELS]  = '0;
    summary_d[SUM_MODFAIL]    = fault_module_in;
    summary_d[SUM_INTERNAL]   = fault_internal_in;
    summary_d[SUM_CHANNEL]    = |chsum_d;
    summary_d[SUM_AUX]        = aux_missing_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      summary_q <= '0;
    end else begin
      summary_q <= summary_d;
    end
  end

  // ----------------------------------------------------------------------
  // Microsecond timer and event stamp
  // ----------------------------------------------------------------------
  // Divider gives the one-cycle microsecond enable
  always_ff @(posedge clk_in) begin
    if (rst_in || us_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  assign us_tick = div_q == US_TICK_CYC - 7'h01;

  // Natural 32-bit wrap returns the timer to zero
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      us_q <= '0;
    end else if (us_tick) begin
      us_q <= us_q + 32'h00000001;
    end
  end

  // Only a newly appearing error counts as a diagnostic event
  assign diag_event = |(summary_d & ~summary_q);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stamp_q <= '0;
    end else if (diag_event) begin
      stamp_q <= us_q;
    end
  end

  // ----------------------------------------------------------------------
  // Diagnostic record read
  // ----------------------------------------------------------------------
  // Byte image in record order; stamp is low byte first
  always_comb begin
    for (int b = 0; b < LEN_FULL; b++) begin
      rec_b[b] = '0;
    end
    rec_b[B_SUMMARY]  = summary_q;
    rec_b[B_MODINFO]  = VAL_MODINFO;
    rec_b[B_SECOND]   = '0;
    rec_b[B_CHKIND]   = VAL_CHKIND;
    rec_b[B_DIAG_BITS_PER_CHANNEL]   = VAL_DIAG_BITS_PER_CHANNEL;
    rec_b[B_CHANNEL_COUNT]    = VAL_CHANNEL_COUNT;
    rec_b[B_CHANNEL_ERROR_SUMMARY]    = {summary_q[SUM_CHANNEL] ? {6'h00, |channel_error_summary_q[1], |channel_error_summary_q[0]}
                                                : 8'h00};
    rec_b[B_CH0]      = channel_error_summary_q[0];
    rec_b[B_CH0 + 1]  = channel_error_summary_q[1];
    for (int k = 0; k < 4; k++) begin
      rec_b[B_STAMP + k] = stamp_q[8*k +: 8];
    end
  end

  // Record number or object index selects full record or its head
  always_comb begin
    if (rd_by_index_in) begin
      rd_full = rd_index_in == IDX_FULL;
      rd_head = rd_index_in == IDX_HEAD;
    end else begin
      rd_full = rd_record_in == REC_FULL;
      rd_head = rd_record_in == REC_HEAD;
    end
  end

  // Answer one cycle after the request; unknown records or bytes past the record end flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_v_q <= 1'b0;
      rd_d_q <= '0;
      rd_e_q <= 1'b0;
    end else begin
      rd_v_q <= rd_en_in;
      if (rd_en_in && ((rd_full && rd_byte_in < LEN_FULL) ||
                       (rd_head && rd_byte_in < LEN_HEAD))) begin
        rd_d_q <= rec_b[rd_byte_in];
        rd_e_q <= 1'b0;
      end else if (rd_en_in) begin
        rd_d_q <= '0;
        rd_e_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------------
  // Errors only light indicators; there is deliberately no interrupt
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      led_q  <= '0;
      mled_q <= 1'b0;
    end else begin
      led_q  <= chsum_d[1:0];
      mled_q <= |summary_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign meas_ready_out = ready_q;
  assign out_valid_out  = head_v_q;
  assign out_chan_out   = head_c_q;
  assign out_value_out  = head_d_q;
  assign rd_valid_out   = rd_v_q;
  assign rd_data_out    = rd_d_q;
  assign rd_err_out     = rd_e_q;
  assign chan_led_out   = led_q;
  assign module_led_out = mled_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  disabled_drop_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (acc && sel_fn == FN_OFF && !head_v_q && !skid_v_q) |=> !head_v_q)
    else $error("Disabled channel sample entered buffer");

  nominal_top_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_fn == FN_0M_27648 && meas_current_in == 16'sd20000) |-> sc_value == 16'sd27648)
    else $error("20 mA did not scale to 27648");

  ceil_clamp_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_fn == FN_0M_27648 && meas_current_in >= 16'sd23520) |-> sc_value == CEIL_27648)
    else $error("Overrange did not stick at 32511");

  floor_clamp_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_fn == FN_0M_16384 && meas_current_in <= -16'sd4000) |-> sc_value == FLOOR_16384)
    else $error("Underrange did not stick at -3277");

  offset_zero_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_fn == FN_4M_16384 && meas_current_in == 16'sd4000) |-> sc_value == 16'sd0)
    else $error("4 mA did not scale to zero");

  over_flag_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (push && !meas_chan_in && sc_over) |=> channel_error_summary_q[0][CH_OVER] && summary_q[SUM_CHANNEL])
    else $error("Overflow not recorded for channel 0");

  led_follow_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (channel_error_summary_q[1] == 8'h00 && $stable(channel_error_summary_q[1])) |-> !chan_led_out[1])
    else $error("Indicator lit without channel error");

  head_len_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_en_in && !rd_by_index_in && rd_record_in == REC_HEAD && rd_byte_in >= LEN_HEAD)
    |=> rd_valid_out && rd_err_out)
    else $error("Head record read past its fourth byte");

  fixed_byte_a : assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_en_in && rd_by_index_in && rd_index_in == IDX_FULL && rd_byte_in == 5'h04)
    |=> rd_data_out == VAL_CHKIND && !rd_err_out)
    else $error("Channel kind byte wrong");

  timer_step_a : assert property (@(posedge clk_in) disable iff (rst_in)
    us_tick |=> us_q == $past(us_q) + 32'h00000001)
    else $error("Microsecond timer did not advance");

endmodule : cisd_top

// File: verification/cisd_coupler_model.sv
`timescale 1ns/1ps
// Bus coupler side of the scaled word stream; it can stall to make the buffer hold words
module cisd_coupler_model (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               stall_in,
  input  wire logic               valid_in,
  input  wire logic signed [15:0] value_in,
  input  wire logic               chan_in,
  output logic                    ready_out,
  output logic                    last_chan_out,
  output logic signed      [15:0] last_out,
  output int                      count_out
);
  // ----
  // Acceptance
  // ----
  // Ready is dropped for the whole stall so no word may be lost meanwhile
  assign ready_out = !stall_in;

  // Capture each accepted word; the count lets the bench spot missing or extra words
  always @(posedge clk_in) begin
    if (rst_in) begin
      count_out <= 0;
    end else if (valid_in && ready_out) begin
      last_out  <= value_in;
      last_chan_out <= chan_in;
      count_out <= count_out + 1;
    end
  end
endmodule : cisd_coupler_model

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cisd_pkg::*;
  logic               clk_in = 0, rst_in = 1, stall = 0, mv = 0, mc = 0, rd_en = 0, by_idx = 0;
  logic               wr_en = 0, f_mod = 0, f_int = 0, aux = 0, ready, ovalid, ordy;
  logic               rvalid, rerr, module_led, ochan, lastch;
  logic signed [15:0] mcur = 0, oval, last;
  logic        [15:0] idx = 0;
  logic        [7:0]  rec, rdata, wrec = 0, wdat = 0;
  logic        [4:0]  rbyte = 0;
  logic        [1:0]  leds;
  int                 bad_count = 0, total_checks = 0, n_words, n0;
  logic        [7:0]  t_code [13] = '{8'h31, 8'h31, 8'h31, 8'h31, 8'h41, 8'h41, 8'h41,
                                      8'h30, 8'h30, 8'h30, 8'h40, 8'h40, 8'h40};
  int                 t_ua   [13] = '{10000, 20000, 23520, -3520, 20000, 25000, -4000,
                                      12000, 23000, 0, 12000, 24000, 800};
  logic        [15:0] t_exp  [13] = '{16'h3600, 16'h6C00, 16'h7EFF, 16'hED00, 16'h4000,
                                      16'h5000, 16'hF333, 16'h3600, 16'h7EFF, 16'hED00,
                                      16'h2000, 16'h5000, 16'hF333};
  logic        [7:0]  t_rec  [20] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h02,
                                      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Record number follows the low index byte; only one of them is used per read
  assign rec = idx[7:0];
  always #5 clk_in = ~clk_in;

  cisd_top dut (.clk_in(clk_in), .rst_in(rst_in), .meas_valid_in(mv), .meas_chan_in(mc),
    .meas_current_in(mcur), .meas_ready_out(ready), .out_valid_out(ovalid),
    .out_ready_in(ordy), .out_chan_out(ochan), .out_value_out(oval), .rd_en_in(rd_en),
    .rd_by_index_in(by_idx), .rd_record_in(rec), .rd_index_in(idx), .rd_byte_in(rbyte),
    .rd_valid_out(rvalid), .rd_data_out(rdata), .rd_err_out(rerr), .wr_en_in(wr_en),
    .wr_record_in(wrec), .wr_data_in(wdat), .fault_module_in(f_mod),
    .fault_internal_in(f_int), .aux_missing_in(aux), .chan_led_out(leds),
    .module_led_out(module_led));
  cisd_coupler_model partner (.clk_in(clk_in), .rst_in(rst_in), .stall_in(stall),
    .valid_in(ovalid), .value_in(oval), .chan_in(ochan), .ready_out(ordy),
    .last_chan_out(lastch), .last_out(last), .count_out(n_words));

  // ----
  // Access tasks
  // ----
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Reader picks the record or index; the answer comes exactly one cycle after the take
  task automatic rd(input logic bi, input logic [15:0] id, input logic [4:0] b,
                    input logic [8:0] exp);
    @(posedge clk_in);
    {rd_en, by_idx, idx, rbyte} <= {1'b1, bi, id, b};
    @(posedge clk_in);
    rd_en <= 0;
    #1 check(16'({rvalid, rerr, rdata}), 16'({1'b1, exp}));
  endtask : rd

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    @(posedge clk_in);
    {wr_en, wrec, wdat} <= {1'b1, r, d};
    @(posedge clk_in);
    wr_en <= 0;
  endtask : wr

  // Hold the sample until the design takes it, bounded in case it never does
  task automatic send(input logic ch, input logic signed [15:0] ua);
    int k;
    k = 0;
    @(posedge clk_in);
    {mv, mc, mcur} <= {1'b1, ch, ua};
    do begin
      @(posedge clk_in);
      k++;
    end while (!ready && k < 50);
    mv <= 0;
    // A sample never taken counts as a mismatch
    check({15'h0, ready}, 16'h0001);
  endtask : send

  task automatic meas(input logic ch, input logic signed [15:0] ua, input logic [15:0] exp);
    int n, k;
    n = n_words;
    k = 0;
    send(ch, ua);
    while (n_words == n && k < 20) begin
      @(posedge clk_in);
      k++;
    end
    check(last, exp);
    check(16'(n_words - n), 16'h0001);
    check({15'h0, lastch}, {15'h0, ch});
  endtask : meas

  task automatic final_report();
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // ----
  // Tests
  // ----
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 0;
    for (int i = 0; i < 20; i++) rd(0, 16'h0001, 5'(i), {1'b0, t_rec[i]});
    rd(0, 16'h0000, 5'h03, 9'h000);
    rd(0, 16'h0000, 5'h04, 9'h100);
    rd(0, 16'h0002, 5'h00, 9'h100);
    rd(1, 16'h2F00, 5'h01, 9'h015);
    rd(1, 16'h2F01, 5'h13, 9'h000);
    rd(1, 16'h2F01, 5'h04, 9'h071);
    rd(1, 16'h2F01, 5'h14, 9'h100);
    rd(1, 16'h2F02, 5'h00, 9'h100);
    for (int i = 0; i < 13; i++) begin
      wr({7'h40, i[0]}, t_code[i]);
      meas(i[0], 16'(t_ua[i]), t_exp[i]);
    end
    repeat (3) @(posedge clk_in);
    rd(0, 16'h0001, 5'h00, 9'h00C);
    rd(0, 16'h0001, 5'h07, 9'h003);
    rd(0, 16'h0001, 5'h08, 9'h040);
    rd(0, 16'h0001, 5'h09, 9'h080);
    check({13'h0, module_led, leds}, 16'h0007);
    meas(0, 16'sd12000, 16'h2000);
    meas(1, 16'sd12000, 16'h2000);
    meas(0, 16'sd4000, 16'h0000);
    repeat (3) @(posedge clk_in);
    rd(0, 16'h0001, 5'h00, 9'h000);
    check({13'h0, module_led, leds}, 16'h0000);
    n0 = n_words;
    wr(8'h80, 8'h55);
    send(0, 16'sd12000);
    repeat (4) @(posedge clk_in);
    rd(0, 16'h0001, 5'h08, 9'h001);
    rd(0, 16'h0001, 5'h00, 9'h088);
    wr(8'h80, 8'hFF);
    send(0, 16'sd12000);
    repeat (6) @(posedge clk_in);
    check(16'(n_words - n0), 16'h0000);
    rd(0, 16'h0001, 5'h08, 9'h000);
    wr(8'h80, 8'h40);
    {f_mod, f_int, aux} <= 3'b111;
    repeat (3) @(posedge clk_in);
    rd(0, 16'h0001, 5'h00, 9'h013);
    @(posedge clk_in);
    {f_mod, f_int, aux, stall} <= 4'h1;
    n0 = n_words;
    // Two words held with the coupler stalled must close the input
    send(0, 16'sd12000);
    send(0, 16'sd12000);
    repeat (3) @(posedge clk_in);
    check({15'h0, ready}, 16'h0000);
    stall <= 0;
    repeat (6) @(posedge clk_in);
    check(16'(n_words - n0), 16'h0002);
    check(last, 16'h2000);
    final_report();
  end

  // Whole sequence needs well under 2000 cycles; give it ten times that
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule : tb_top
